// ### cvio_pkg.sv
// package of constants and types for the converter discrete io supervision block
package cvio_pkg;

  // clock and timing
  localparam int unsigned CLK_FREQ_HZ        = 100_000_000;
  localparam int unsigned RESET_MIN_MS       = 100;
  localparam int unsigned RESET_MIN_CYCLES   = (CLK_FREQ_HZ / 1000) * RESET_MIN_MS;
  localparam int unsigned DEBOUNCE_US        = 1000;
  localparam int unsigned DEBOUNCE_CYCLES    = (CLK_FREQ_HZ / 1_000_000) * DEBOUNCE_US;
  localparam int unsigned STARTUP_US         = 1000;
  localparam int unsigned STARTUP_CYCLES     = (CLK_FREQ_HZ / 1_000_000) * STARTUP_US;

  // converter setting switch positions
  localparam logic [3:0]  SETTING_NO_CONTACTOR = 4'h1;
  localparam logic [3:0]  SETTING_FORCED_STOP  = 4'h4;

  // interrupt status / mask bit positions
  localparam int unsigned EVT_ALARM_BIT      = 0;
  localparam int unsigned EVT_FSTOP_BIT      = 1;
  localparam int unsigned EVT_RESET_BIT      = 2;
  localparam int unsigned EVT_READY_BIT      = 3;
  localparam int unsigned EVT_WIDTH          = 4;

  // register offsets
  localparam logic [3:0]  REG_STATUS_OFS     = 4'h0;
  localparam logic [3:0]  REG_EVENT_OFS      = 4'h4;
  localparam logic [3:0]  REG_MASK_OFS       = 4'h8;
  localparam logic [3:0]  REG_CAUSE_OFS      = 4'hC;

  // reset values
  localparam logic [EVT_WIDTH-1:0] MASK_RESET = 4'h0;

  // operating states, one-hot
  typedef enum logic [4:0] {
    CVIO_STARTUP = 5'b00001,
    CVIO_READY   = 5'b00010,
    CVIO_RUN     = 5'b00100,
    CVIO_FSTOP   = 5'b01000,
    CVIO_ALARM   = 5'b10000
  } cvio_state_type;

endpackage : cvio_pkg

// ### cvio_debounce.sv
// synchroniser and debounce filter for discrete inputs
`timescale 1ns/100ps
`default_nettype none

module cvio_debounce
  import cvio_pkg::*;
#(
  parameter int unsigned COUNT = DEBOUNCE_CYCLES
)(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // raw and filtered level
  input  wire logic raw_i,
  output logic      level_o
);

  localparam int unsigned CW = $clog2(COUNT + 1);

  logic          sync1_reg;
  logic          sync2_reg;
  logic          level_reg;
  logic          level_next;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] cnt_next;

  always_comb
  begin
    level_next = level_reg;
    cnt_next   = '0;
    if (sync2_reg != level_reg)
    begin
      // accept a new level only after it holds steadily for the whole window
      if (cnt_reg == CW'(COUNT - 1))
        level_next = sync2_reg;
      else
        cnt_next = cnt_reg + CW'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      level_reg <= 1'b0;
      cnt_reg   <= '0;
    end
    else
    begin
      sync1_reg <= raw_i;
      sync2_reg <= sync1_reg;
      level_reg <= level_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign level_o = level_reg;

endmodule : cvio_debounce

`default_nettype wire

// ### cvio_top.sv
// converter discrete io supervision: inputs, status outputs, alarm relay, registers
//
// Behaviour
// - forced-stop input only honoured when setting switch is at position 4
// - forced-stop input off enters forced stop, opens contactor, servo off
// - forced-stop input back on while stopped releases forced stop
// - alarm reset clears resettable alarms; non-resettable causes stay
// - alarm reset with no alarm present returns to ready-off
// - alarm ok output on without alarm, off whenever an alarm occurs; the code also holds it off until startup completes
// - ready output on when ready, off from power-up until startup completes
// - fault-or-reset output on at error or reset, off until startup completes
// - after startup fault-or-reset output is inverse of ready output
// - reset echo output on while alarm reset input applied
// - alarm relay in error position when protection tripped and output stopped
// - error: B-C open, A-C closed; normal: B-C closed, A-C open
// - start command from drive unit closes contactor drive contact
// - setting switch position 1 leaves contactor control connector unused
//
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module cvio_top
  import cvio_pkg::*;
#(
  parameter int unsigned RESET_CYCLES    = RESET_MIN_CYCLES,
  parameter int unsigned DEBOUNCE_COUNT  = DEBOUNCE_CYCLES,
  parameter int unsigned STARTUP_COUNT   = STARTUP_CYCLES,
  parameter int unsigned CAUSE_WIDTH     = 8,
  parameter logic [7:0]  FIXED_CAUSES    = 8'hF0
)(
  // clock and reset
  input  wire logic                   clk_sys_i,
  input  wire logic                   resetn_i,
  // discrete inputs, active high = on
  input  wire logic                   forced_stop_input_i,
  input  wire logic                   alarm_reset_input_i,
  input  wire logic [3:0]             converter_setting_switch_i,
  // internal unit interface
  input  wire logic                   start_command_i,
  input  wire logic [CAUSE_WIDTH-1:0] alarm_cause_i,
  // discrete outputs
  output logic                        alarm_ok_output_o,
  output logic                        converter_ready_output_o,
  output logic                        fault_or_reset_output_o,
  output logic                        reset_echo_output_o,
  output logic                        contactor_drive_closed_o,
  output logic                        servo_off_o,
  output logic                        drive_output_stopped_o,
  // alarm relay contacts, high = closed
  output logic                        relay_ac_closed_o,
  output logic                        relay_bc_closed_o,
  // register port
  input  wire logic [3:0]             reg_addr_i,
  input  wire logic [31:0]            reg_wdata_i,
  input  wire logic                   reg_write_i,
  input  wire logic                   reg_read_i,
  output logic [31:0]                 reg_rdata_o,
  output logic                        irq_o
);

  // startup outlasts the input filters, so a line that idles high has settled
  // before the first state decision and cannot fake a forced stop
  localparam int unsigned BOOT_COUNT = (STARTUP_COUNT > DEBOUNCE_COUNT + 3) ? STARTUP_COUNT
                                                                            : DEBOUNCE_COUNT + 3;
  localparam int unsigned RW         = $clog2(RESET_CYCLES + 1);
  localparam int unsigned SW         = $clog2(BOOT_COUNT + 1);

  ////////////////////////////////////////////////////////////////////////////
  // input conditioning

  logic fstop_on;
  logic reset_on;

  cvio_debounce #(
    .COUNT     (DEBOUNCE_COUNT)
  ) u_db_fstop (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .raw_i     (forced_stop_input_i),
    .level_o   (fstop_on)
  );

  cvio_debounce #(
    .COUNT     (DEBOUNCE_COUNT)
  ) u_db_reset (
    .clk_sys_i (clk_sys_i),
    .resetn_i  (resetn_i),
    .raw_i     (alarm_reset_input_i),
    .level_o   (reset_on)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state machine, alarm latch and reset width

  cvio_state_type         state_reg;
  cvio_state_type         state_next;
  logic [CAUSE_WIDTH-1:0] cause_reg;
  logic [CAUSE_WIDTH-1:0] cause_next;
  logic [RW-1:0]          rst_cnt_reg;
  logic [RW-1:0]          rst_cnt_next;
  logic [SW-1:0]          boot_cnt_reg;
  logic [SW-1:0]          boot_cnt_next;
  logic                   reset_prev_reg;
  logic                   reset_prev_next;
  logic                   fstop_en;
  logic                   reset_valid;
  logic                   alarm_now;

  // forced stop input only counts at its dedicated switch setting
  assign fstop_en    = (converter_setting_switch_i == SETTING_FORCED_STOP);
  // a reset pulse counts only once it has been held long enough
  assign reset_valid = reset_on && (rst_cnt_reg == RW'(RESET_CYCLES));
  assign alarm_now   = |(cause_reg | alarm_cause_i);

  always_comb
  begin
    state_next      = state_reg;
    cause_next      = cause_reg | alarm_cause_i;
    boot_cnt_next   = boot_cnt_reg;
    // act once on the rising edge of a qualified reset
    if (reset_valid && !reset_prev_reg)
      cause_next = (cause_reg & FIXED_CAUSES[CAUSE_WIDTH-1:0]) | alarm_cause_i;
    case (state_reg)
      CVIO_STARTUP:
      begin
        if (boot_cnt_reg == SW'(BOOT_COUNT))
          state_next = CVIO_READY;
        else
          boot_cnt_next = boot_cnt_reg + SW'(1);
      end
      CVIO_READY:
      begin
        if (alarm_now)
          state_next = CVIO_ALARM;
        else if (fstop_en && !fstop_on)
          state_next = CVIO_FSTOP;
        else if (start_command_i && !reset_on)
          state_next = CVIO_RUN;
      end
      CVIO_RUN:
      begin
        if (alarm_now)
          state_next = CVIO_ALARM;
        else if (fstop_en && !fstop_on)
          state_next = CVIO_FSTOP;
        else if (reset_valid || !start_command_i)
          state_next = CVIO_READY;
      end
      CVIO_FSTOP:
      begin
        if (alarm_now)
          state_next = CVIO_ALARM;
        else if (!fstop_en || fstop_on)
          state_next = CVIO_READY;
      end
      CVIO_ALARM:
      begin
        // leave only when the reset edge has emptied the latch and no cause is
        // still driven; a fixed cause holds the alarm until the next power-up
        if (reset_valid && !reset_prev_reg && cause_next == '0)
          state_next = CVIO_READY;
      end
      default:
        state_next = CVIO_STARTUP;
    endcase
    // reset with no alarm drops any running state back to ready-off
    if (state_reg == CVIO_RUN && reset_valid && !alarm_now)
      state_next = CVIO_READY;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      state_reg      <= CVIO_STARTUP;
      cause_reg      <= '0;
      boot_cnt_reg   <= '0;
    end
    else
    begin
      state_reg      <= state_next;
      cause_reg      <= cause_next;
      boot_cnt_reg   <= boot_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reset pulse qualification

  always_comb
  begin
    rst_cnt_next    = rst_cnt_reg;
    reset_prev_next = reset_valid;
    // the count saturates, so a long hold still gives one qualified edge
    if (!reset_on)
      rst_cnt_next = '0;
    else if (rst_cnt_reg != RW'(RESET_CYCLES))
      rst_cnt_next = rst_cnt_reg + RW'(1);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rst_cnt_reg    <= '0;
      reset_prev_reg <= 1'b0;
    end
    else
    begin
      rst_cnt_reg    <= rst_cnt_next;
      reset_prev_reg <= reset_prev_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs

  logic out_alm_reg;
  logic out_alm_next;
  logic out_rdy_reg;
  logic out_rdy_next;
  logic out_flt_reg;
  logic out_flt_next;
  logic out_rso_reg;
  logic out_rso_next;
  logic out_mc_reg;
  logic out_mc_next;
  logic out_rly_reg;
  logic out_rly_next;
  logic booted;

  assign booted = (state_reg != CVIO_STARTUP);

  always_comb
  begin
    out_alm_next = booted && !alarm_now;
    out_rdy_next = booted && !alarm_now && !reset_on
                   && (state_reg == CVIO_READY || state_reg == CVIO_RUN);
    out_flt_next = booted && !out_rdy_next;
    out_rso_next = reset_on;
    // position 1 means the contactor connector is not used for control
    out_mc_next  = (state_next == CVIO_RUN)
                   && (converter_setting_switch_i != SETTING_NO_CONTACTOR);
    out_rly_next = (state_next == CVIO_ALARM);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      out_alm_reg <= 1'b0;
      out_rdy_reg <= 1'b0;
      out_flt_reg <= 1'b0;
      out_rso_reg <= 1'b0;
      out_mc_reg  <= 1'b0;
      out_rly_reg <= 1'b0;
    end
    else
    begin
      out_alm_reg <= out_alm_next;
      out_rdy_reg <= out_rdy_next;
      out_flt_reg <= out_flt_next;
      out_rso_reg <= out_rso_next;
      out_mc_reg  <= out_mc_next;
      out_rly_reg <= out_rly_next;
    end
  end

  // registered drivers only, so the pins never glitch
  assign alarm_ok_output_o        = out_alm_reg;
  assign converter_ready_output_o = out_rdy_reg;
  assign fault_or_reset_output_o  = out_flt_reg;
  assign reset_echo_output_o      = out_rso_reg;
  assign contactor_drive_closed_o = out_mc_reg;
  assign servo_off_o              = !out_mc_reg;
  assign drive_output_stopped_o   = out_rly_reg;
  assign relay_ac_closed_o        = out_rly_reg;
  assign relay_bc_closed_o        = !out_rly_reg;

  ////////////////////////////////////////////////////////////////////////////
  // events, mask and register port

  logic [EVT_WIDTH-1:0] evt_reg;
  logic [EVT_WIDTH-1:0] evt_next;
  logic [EVT_WIDTH-1:0] mask_reg;
  logic [EVT_WIDTH-1:0] mask_next;
  logic [EVT_WIDTH-1:0] evt_set;
  logic [31:0]          rdata_reg;
  logic [31:0]          rdata_next;

  always_comb
  begin
    evt_set                = '0;
    evt_set[EVT_ALARM_BIT] = out_rly_next && !out_rly_reg;
    evt_set[EVT_FSTOP_BIT] = (state_next == CVIO_FSTOP) && (state_reg != CVIO_FSTOP);
    evt_set[EVT_RESET_BIT] = reset_valid && !reset_prev_reg;
    evt_set[EVT_READY_BIT] = out_rdy_next && !out_rdy_reg;
    mask_next              = mask_reg;
    evt_next               = evt_reg;
    if (reg_write_i && reg_addr_i == REG_EVENT_OFS)
      evt_next = evt_reg & ~reg_wdata_i[EVT_WIDTH-1:0];
    // a new event in the clearing cycle wins over the clear
    evt_next = evt_next | evt_set;
    if (reg_write_i && reg_addr_i == REG_MASK_OFS)
      mask_next = reg_wdata_i[EVT_WIDTH-1:0];
    rdata_next = 32'h0000_0000;
    if (reg_read_i)
    begin
      case (reg_addr_i)
        REG_STATUS_OFS: rdata_next = {21'h0, out_rly_reg, out_mc_reg, out_rso_reg, out_flt_reg,
                                      out_rdy_reg, out_alm_reg, state_reg};
        REG_EVENT_OFS:  rdata_next = {{(32-EVT_WIDTH){1'b0}}, evt_reg};
        REG_MASK_OFS:   rdata_next = {{(32-EVT_WIDTH){1'b0}}, mask_reg};
        REG_CAUSE_OFS:  rdata_next = 32'(cause_reg);
        default:        rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      evt_reg   <= '0;
      mask_reg  <= MASK_RESET;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      evt_reg   <= evt_next;
      mask_reg  <= mask_next;
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_o = rdata_reg;
  assign irq_o       = |(evt_reg & mask_reg);

endmodule : cvio_top

`default_nettype wire

// ### cvio_sva.sv
// checker of the converter io supervision outputs
`timescale 1ns/100ps
`default_nettype none
module cvio_sva
  import cvio_pkg::*;
#(
  parameter int unsigned STARTUP_COUNT = 10
)(
  // clock and reset
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  // watched ports
  input wire logic       forced_stop_input_i,
  input wire logic       alarm_reset_input_i,
  input wire logic [3:0] converter_setting_switch_i,
  input wire logic       alarm_ok_output_o,
  input wire logic       converter_ready_output_o,
  input wire logic       fault_or_reset_output_o,
  input wire logic       reset_echo_output_o,
  input wire logic       contactor_drive_closed_o,
  input wire logic       servo_off_o,
  input wire logic       drive_output_stopped_o,
  input wire logic       relay_ac_closed_o,
  input wire logic       relay_bc_closed_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  ////////////////////////////////////////////////////////////////////////
  // cycles since reset release, saturating so long runs stay quiet
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        fstop_req;
  assign fstop_req = (converter_setting_switch_i == SETTING_FORCED_STOP) && !forced_stop_input_i;
  always_comb cnt_next = (cnt_reg == 16'hFFFF) ? cnt_reg : cnt_reg + 16'h1;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i)
      cnt_reg <= 16'h0;
    else
      cnt_reg <= cnt_next;
  ////////////////////////////////////////////////////////////////////////
  a_startup_quiet: assert property (
    cnt_reg < STARTUP_COUNT |-> !converter_ready_output_o && !fault_or_reset_output_o)
    else $error("ready or fault output on during startup");
  a_fault_inverse_ready: assert property (
    cnt_reg > STARTUP_COUNT + 4 |-> fault_or_reset_output_o != converter_ready_output_o)
    else $error("fault output not inverse of ready");
  a_relay_changeover: assert property (relay_ac_closed_o != relay_bc_closed_o)
    else $error("relay contacts not in changeover");
  a_relay_drive_stop: assert property (relay_ac_closed_o == drive_output_stopped_o)
    else $error("relay position differs from drive stop");
  a_stop_not_ok: assert property (drive_output_stopped_o |-> !alarm_ok_output_o)
    else $error("alarm ok on while drive stopped");
  a_servo_contactor: assert property (servo_off_o == !contactor_drive_closed_o)
    else $error("servo off not inverse of contactor");
  a_ready_no_alarm: assert property (converter_ready_output_o |-> alarm_ok_output_o)
    else $error("ready on while alarm present");
  a_echo_follows_reset: assert property (
    alarm_reset_input_i[*8] ##1 alarm_reset_input_i[*4] |-> reset_echo_output_o)
    else $error("reset echo missing while reset held");
  a_echo_rise_cause: assert property ($rose(reset_echo_output_o) |-> $past(alarm_reset_input_i, 3))
    else $error("reset echo rose without held reset input");
  a_fstop_opens: assert property (
    fstop_req[*8] ##1 fstop_req[*4] |-> !contactor_drive_closed_o && servo_off_o)
    else $error("contactor closed during forced stop");
endmodule : cvio_sva
`default_nettype wire

// ### cvio_ctrl_model.sv
// model of the external controller driving the discrete inputs
`timescale 1ns/100ps
`default_nettype none
module cvio_ctrl_model #(
  parameter int unsigned HOLD = 40
)(
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  // bench commands
  input  wire logic fstop_cmd_i,
  input  wire logic reset_cmd_i,
  input  wire logic run_i,
  // discrete lines
  output logic      forced_stop_o,
  output logic      alarm_reset_o
);
  int unsigned left;
  assign forced_stop_o = fstop_cmd_i;
  // a reset request is ignored while running, it is no stop mechanism
  always @(posedge clk_sys_i or negedge resetn_i)
    if (!resetn_i)
    begin
      left <= 0;
      alarm_reset_o <= 1'b0;
    end
    else if (left != 0)
    begin
      left <= left - 1;
      alarm_reset_o <= (left != 1);
    end
    else if (reset_cmd_i && !run_i)
    begin
      left <= HOLD;
      alarm_reset_o <= 1'b1;
    end
endmodule : cvio_ctrl_model
`default_nettype wire

// ### cvio_top_test.sv
// self-checking bench of the converter io supervision block
`timescale 1ns/100ps
`default_nettype none
module cvio_top_test;
  import cvio_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        fstop_cmd = 1'b1;
  logic        reset_cmd = 1'b0;
  logic        fstop_in;
  logic        ares_in;
  logic [3:0]  sw = 4'h4;
  logic        start = 1'b0;
  logic [7:0]  cause = 8'h00;
  logic        alm_ok, rdy, flt, echo, mc, soff, stopped, ac, bc, irq;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  int          n_fail = 0;
  int          comparisons = 0;
  int          cyc = 0;
  always #5 clk = ~clk;
  cvio_ctrl_model #(.HOLD(40)) ctrl_u (.clk_sys_i(clk), .resetn_i(resetn), .fstop_cmd_i(fstop_cmd),
    .reset_cmd_i(reset_cmd), .run_i(start), .forced_stop_o(fstop_in), .alarm_reset_o(ares_in));
  // short counts keep the run small; the reset hold of the model exceeds them
  cvio_top #(.RESET_CYCLES(20), .DEBOUNCE_COUNT(4), .STARTUP_COUNT(10)) dut_u (.clk_sys_i(clk),
    .resetn_i(resetn), .forced_stop_input_i(fstop_in), .alarm_reset_input_i(ares_in),
    .converter_setting_switch_i(sw), .start_command_i(start), .alarm_cause_i(cause),
    .alarm_ok_output_o(alm_ok), .converter_ready_output_o(rdy), .fault_or_reset_output_o(flt),
    .reset_echo_output_o(echo), .contactor_drive_closed_o(mc), .servo_off_o(soff),
    .drive_output_stopped_o(stopped), .relay_ac_closed_o(ac), .relay_bc_closed_o(bc),
    .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata), .irq_o(irq));
  ////////////////////////////////////////////////////////////////////////
  task give_verdict;
    $display("failures %0d comparisons %0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task chk(input logic ok, input string msg);
    comparisons++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask : chk
  task automatic await(ref logic s, input logic v);
    for (int i = 0; i < 120 && s !== v; i++)
      @(posedge clk);
    #1;
    chk(s === v, "output level not reached");
    // hand back on a rising edge so the caller drives its next input there
    @(posedge clk);
  endtask : await
  task reg_wr(input logic [3:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : reg_wr
  task reg_rd(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] msk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk((rdata & msk) === exp, "register read mismatch");
    @(posedge clk);
  endtask : reg_rd
  task pulse_reset;
    reset_cmd <= 1'b1;
    @(posedge clk);
    reset_cmd <= 1'b0;
  endtask : pulse_reset
  ////////////////////////////////////////////////////////////////////////
  task t_startup;
    await(rdy, 1'b1);
    chk(alm_ok === 1'b1 && flt === 1'b0 && bc === 1'b1 && ac === 1'b0, "idle outputs");
    reg_rd(REG_MASK_OFS, 32'h0 | MASK_RESET, 32'h0000000F);
    reg_rd(4'h2, 32'h0, 32'hFFFFFFFF);
    reg_wr(REG_MASK_OFS, 32'h0000000F);
    reg_rd(REG_MASK_OFS, 32'h0000000F, 32'h0000000F);
    reg_rd(REG_STATUS_OFS, 32'h0 | CVIO_READY, 32'h0000001F);
  endtask : t_startup
  task t_forced_stop;
    start <= 1'b1;
    await(mc, 1'b1);
    fstop_cmd <= 1'b0;
    await(mc, 1'b0);
    chk(soff === 1'b1 && irq === 1'b1, "servo off and interrupt");
    reg_rd(REG_STATUS_OFS, 32'h0 | CVIO_FSTOP, 32'h0000001F);
    fstop_cmd <= 1'b1;
    await(rdy, 1'b1);
    reg_rd(REG_STATUS_OFS, 32'h0, 32'h00000008);
    reg_wr(REG_EVENT_OFS, 32'h0000000F);
    reg_rd(REG_EVENT_OFS, 32'h0, 32'h0000000F);
    chk(irq === 1'b0, "interrupt after clear");
    sw <= 4'h0;
    fstop_cmd <= 1'b0;
    repeat (20) @(posedge clk);
    reg_rd(REG_STATUS_OFS, 32'h0, 32'h00000008);
    chk(mc === 1'b1, "contactor opened with forced stop disabled");
    // let the filter see the line high again before the stop is re-armed
    fstop_cmd <= 1'b1;
    start <= 1'b0;
    repeat (10) @(posedge clk);
    sw <= SETTING_FORCED_STOP;
  endtask : t_forced_stop
  task t_alarm_reset;
    cause <= 8'h01;
    await(alm_ok, 1'b0);
    chk(ac === 1'b1 && bc === 1'b0 && stopped === 1'b1 && flt === 1'b1 && rdy === 1'b0, "alarm outputs");
    reg_rd(REG_CAUSE_OFS, 32'h00000001, 32'h000000FF);
    reg_rd(REG_EVENT_OFS, 32'h00000001, 32'h0000000F);
    cause <= 8'h00;
    pulse_reset();
    await(echo, 1'b1);
    chk(flt === 1'b1, "fault output during reset");
    await(alm_ok, 1'b1);
    reg_rd(REG_CAUSE_OFS, 32'h0, 32'h000000FF);
    await(echo, 1'b0);
    await(rdy, 1'b1);
    // alarm entered, qualified reset and ready rose, none cleared since
    reg_rd(REG_EVENT_OFS, 32'h0000000D, 32'h0000000F);
  endtask : t_alarm_reset
  task t_reset_no_alarm;
    pulse_reset();
    await(echo, 1'b1);
    await(rdy, 1'b0);
    chk(flt === 1'b1 && alm_ok === 1'b1, "ready off without alarm");
    await(echo, 1'b0);
  endtask : t_reset_no_alarm
  task t_no_contactor;
    sw <= SETTING_NO_CONTACTOR;
    start <= 1'b1;
    repeat (10) @(posedge clk);
    chk(mc === 1'b0 && soff === 1'b1 && rdy === 1'b1, "contactor closed at setting one");
    reg_rd(REG_STATUS_OFS, 32'h0 | CVIO_RUN, 32'h0000001F);
    start <= 1'b0;
    sw <= SETTING_FORCED_STOP;
  endtask : t_no_contactor
  task t_fixed_cause;
    cause <= 8'h10;
    await(alm_ok, 1'b0);
    cause <= 8'h00;
    pulse_reset();
    await(echo, 1'b1);
    await(echo, 1'b0);
    chk(alm_ok === 1'b0 && ac === 1'b1, "fixed cause kept alarm");
    reg_rd(REG_CAUSE_OFS, 32'h00000010, 32'h000000FF);
  endtask : t_fixed_cause
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_fail++;
      give_verdict();
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    t_startup();
    t_forced_stop();
    t_alarm_reset();
    t_reset_no_alarm();
    t_no_contactor();
    t_fixed_cause();
    give_verdict();
  end
endmodule : cvio_top_test
bind cvio_top cvio_sva #(.STARTUP_COUNT(STARTUP_COUNT)) sva_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
  .forced_stop_input_i(forced_stop_input_i), .alarm_reset_input_i(alarm_reset_input_i),
  .converter_setting_switch_i(converter_setting_switch_i), .alarm_ok_output_o(alarm_ok_output_o),
  .converter_ready_output_o(converter_ready_output_o), .fault_or_reset_output_o(fault_or_reset_output_o),
  .reset_echo_output_o(reset_echo_output_o), .contactor_drive_closed_o(contactor_drive_closed_o),
  .servo_off_o(servo_off_o), .drive_output_stopped_o(drive_output_stopped_o),
  .relay_ac_closed_o(relay_ac_closed_o), .relay_bc_closed_o(relay_bc_closed_o));
`default_nettype wire
